// ==== shared/wake_consts.vh ====
// Constants for the Ethernet wake detection block
`ifndef WAKE_CONSTS_VH
`define WAKE_CONSTS_VH
`define SYNC_BYTE 8'hFF
`define SYNC_LEN 4'h6
`define ADDR_REPS 5'h10
`define ADDR_BYTES 3'h6
`define WAKE_FRAMES 4
`define ACL_ENTRIES 8
`define FIFO_WIDTH 10
`define FIFO_DEPTH 16
`define STAT_LINK 0
`define STAT_FRAME 1
`define STAT_PATTERN 2
`endif

// ==== hdl/wake_fifo.v ====
// Synchronous FIFO with valid/ready on both sides
`timescale 1ns/1ps
module wake_fifo #(
  parameter WIDTH = 10,
  parameter DEPTH = 16,
  parameter AW = 4
)(
  // Clock and reset
  input wire mclk,
  input wire reset_n,
  // Fill side
  input wire inValid,
  output wire inReady,
  input wire [WIDTH-1:0] inData,
  // Drain side
  output wire outValid,
  input wire outReady,
  output reg [WIDTH-1:0] outData
);
  // ==========================================
  // Storage
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wrPtr_r;
  reg [AW-1:0] rdPtr_r;
  reg [AW:0] count_r;
  wire doWr = inValid && inReady;
  wire doRd = outValid && outReady;
  assign inReady = (count_r != DEPTH[AW:0]);
  assign outValid = (count_r != {(AW+1){1'b0}});
  always @*
  begin
    outData = mem[rdPtr_r];
  end
  always @(posedge mclk)
  begin
    if (doWr)
      mem[wrPtr_r] <= inData;
  end
  always @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      wrPtr_r <= {AW{1'b0}};
      rdPtr_r <= {AW{1'b0}};
      count_r <= {(AW+1){1'b0}};
    end
    else
    begin
      if (doWr)
        wrPtr_r <= wrPtr_r + 1'b1;
      if (doRd)
        rdPtr_r <= rdPtr_r + 1'b1;
      if (doWr && !doRd)
        count_r <= count_r + 1'b1;
      else if (doRd && !doWr)
        count_r <= count_r - 1'b1;
    end
  end
endmodule // wake_fifo

// ==== hdl/wake_crc32.v ====
// Byte-wise Ethernet CRC-32 accumulator
`timescale 1ns/1ps
module wake_crc32 (
  // Clock and reset
  input wire mclk,
  input wire reset_n,
  // Byte stream
  input wire clear,
  input wire byteEn,
  input wire [7:0] byteIn,
  // Running remainder
  output reg [31:0] crc
);
  // ==========================================
  // Reflected polynomial, one bit per step
  reg [31:0] c;
  integer i;
  always @*
  begin
    c = crc;
    for (i = 0; i < 8; i = i + 1)
      c = (c[0] ^ byteIn[i]) ? ((c >> 1) ^ 32'hEDB88320) : (c >> 1);
  end
  always @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
      crc <= 32'hFFFFFFFF;
    else if (clear)
      crc <= 32'hFFFFFFFF;
    else if (byteEn)
      crc <= c;
  end
endmodule // wake_crc32

// ==== hdl/ethernet_wake_detect.v ====
// Receive-side wake detection and IPv6 checksum/filter control for one MAC port
//
// Contract
// RULE_01: Link change either way raises wake event
// RULE_02: Four programmed wake frames matched by CRC
// RULE_03: Pattern scan only while pattern mode enabled
// RULE_04: Station address sixteen times back to back
// RULE_05: Preceded by six bytes of FF
// RULE_06: Sequence found at any payload position
// RULE_07: Broadcast frames also scanned for pattern
// RULE_08: Valid frame: own, multicast, broadcast; good CRC
// RULE_09: No other content constraints on pattern
// RULE_10: Frame without sequence dropped, no action
// RULE_11: Found sequence alerts power management
// RULE_12: IPv6 checksum insert by static or descriptor
// RULE_13: Drop IPv6 frames with checksum error
// RULE_14: Eight ACL entries on source or destination
// RULE_15: Mismatch restarts scan, byte may start sync
// RULE_16: Wake source recorded, software readable, clearable
// RULE_17: Exactly three wake sources
`timescale 1ns/1ps
`include "wake_consts.vh"
module ethernet_wake_detect #(
  parameter NFRM = `WAKE_FRAMES,
  parameter NACL = `ACL_ENTRIES,
  parameter FW = `FIFO_WIDTH,
  parameter FD = `FIFO_DEPTH
)(
  // Clock and reset
  input wire mclk,
  input wire reset_n,
  // Link from PHY side (foreign domain)
  input wire rxClk,
  input wire rxDv,
  input wire [7:0] rxData,
  input wire linkUp,
  // Configuration
  input wire patternEnable,
  input wire [47:0] stationAddr,
  input wire [NFRM*32-1:0] wakeFrameCrc,
  input wire [NFRM-1:0] wakeFrameEn,
  input wire wakeFrameMode,
  // IPv6 offload
  input wire txCsumStatic,
  input wire [31:0] tx_descriptor_word_one,
  input wire rxCsumFilterEn,
  input wire rxIpv6,
  input wire rxL4CsumErr,
  input wire [NACL*128-1:0] aclAddr,
  input wire [NACL-1:0] aclUseDest,
  input wire [NACL-1:0] aclValid,
  input wire [127:0] rxSrcIp,
  input wire [127:0] rxDstIp,
  // Status
  input wire [2:0] wakeStatusClr,
  output reg [2:0] wakeStatus_r,
  output reg wakeRequest_r,
  output reg wake_pattern_frame_r,
  output reg frameDrop_r,
  output wire txCsumInsert,
  output wire rxIpv6Drop,
  output wire aclHit
);
  // ==========================================
  // Synchronisers for pins
  reg [1:0] clkSync_r;
  reg [1:0] dvSync_r;
  reg [1:0] linkSync_r;
  reg [7:0] dataS1_r;
  reg [7:0] dataS2_r;
  reg clkPrev_r;
  reg linkPrev_r;
  always @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      clkSync_r <= 2'h0;
      dvSync_r <= 2'h0;
      linkSync_r <= 2'h0;
      dataS1_r <= 8'h00;
      dataS2_r <= 8'h00;
      clkPrev_r <= 1'b0;
      linkPrev_r <= 1'b0;
    end
    else
    begin
      clkSync_r <= {clkSync_r[0], rxClk};
      dvSync_r <= {dvSync_r[0], rxDv};
      linkSync_r <= {linkSync_r[0], linkUp};
      dataS1_r <= rxData;
      dataS2_r <= dataS1_r;
      clkPrev_r <= clkSync_r[1];
      linkPrev_r <= linkSync_r[1];
    end
  end
  // Link clock is slow, so rising edge sampling of settled data is safe
  wire rxEdge = clkSync_r[1] && !clkPrev_r;
  wire linkChange = linkSync_r[1] ^ linkPrev_r; // [RULE_01]
  // ==========================================
  // Byte FIFO: bit 9 start, bit 8 end-of-frame marker
  reg dvPrev_r;
  reg inFrame_r;
  wire fifoInValid = rxEdge && (dvSync_r[1] || dvPrev_r);
  wire fifoInReady;
  wire [FW-1:0] fifoInData = {dvSync_r[1] && !dvPrev_r, !dvSync_r[1], dataS2_r};
  wire fifoOutValid;
  wire [FW-1:0] fifoOutData;
  always @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
      dvPrev_r <= 1'b0;
    else if (rxEdge)
      dvPrev_r <= dvSync_r[1];
  end
  // Drain always ready; back-pressure only matters if consumer stalls
  wake_fifo #(.WIDTH(FW), .DEPTH(FD), .AW(4)) uFifo (
    .mclk(mclk),
    .reset_n(reset_n),
    .inValid(fifoInValid),
    .inReady(fifoInReady),
    .inData(fifoInData),
    .outValid(fifoOutValid),
    .outReady(1'b1),
    .outData(fifoOutData)
  );
  wire byteV = fifoOutValid && !fifoOutData[8];
  wire startB = byteV && fifoOutData[9];
  wire eof = fifoOutValid && fifoOutData[8];
  wire [7:0] b = fifoOutData[7:0];
  // Frame overrun when FIFO fills: frame marked bad
  reg overrun_r;
  // ==========================================
  // CRC and address check
  wire [31:0] crc;
  wake_crc32 uCrc (
    .mclk(mclk),
    .reset_n(reset_n),
    .clear(eof),
    .byteEn(byteV),
    .byteIn(b),
    .crc(crc)
  );
  wire crcGood = (crc == 32'hDEBB20E3);
  reg [10:0] pos_r;
  reg daOwn_r;
  reg daBcast_r;
  reg daMcast_r;
  wire [7:0] addrByte = stationAddr[47 - 8*pos_r[2:0] -: 8];
  // ==========================================
  // Pattern scanner
  localparam S_SYNC = 1'b0;
  localparam S_ADDR = 1'b1;
  reg state_r;
  reg [3:0] syncCnt_r;
  reg [2:0] byteIdx_r;
  reg [4:0] repCnt_r;
  reg found_r;
  wire [7:0] expByte = stationAddr[47 - 8*byteIdx_r -: 8];
  always @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state_r <= S_SYNC;
      syncCnt_r <= 4'h0;
      byteIdx_r <= 3'h0;
      repCnt_r <= 5'h00;
      found_r <= 1'b0;
      pos_r <= 11'h000;
      daOwn_r <= 1'b1;
      daBcast_r <= 1'b1;
      daMcast_r <= 1'b0;
      inFrame_r <= 1'b0;
      overrun_r <= 1'b0;
    end
    else
    begin
      if (startB || eof)
      begin
        state_r <= S_SYNC;
        syncCnt_r <= 4'h0;
        byteIdx_r <= 3'h0;
        repCnt_r <= 5'h00;
        found_r <= 1'b0;
        pos_r <= 11'h000;
        daOwn_r <= 1'b1;
        daBcast_r <= 1'b1;
        inFrame_r <= startB;
        if (eof)
          overrun_r <= 1'b0;
      end
      // A push in the end cycle belongs to the next frame, so set wins
      if (fifoInValid && !fifoInReady)
        overrun_r <= 1'b1;
      if (byteV)
      begin
        if (pos_r != 11'h7FF)
          pos_r <= (startB ? 11'h000 : pos_r) + 11'h001;
        if (startB || pos_r < 11'h006)
        begin
          if (b != (startB ? stationAddr[47:40] : addrByte))
            daOwn_r <= 1'b0;
          if (b != 8'hFF)
            daBcast_r <= 1'b0;
          if (startB)
            daMcast_r <= b[0];
        end
        // Scan at any position; content otherwise unconstrained [RULE_06] [RULE_09]
        case (state_r)
          S_SYNC:
          begin
            if (b == `SYNC_BYTE) // [RULE_05]
            begin
              if (syncCnt_r + 4'h1 >= `SYNC_LEN)
              begin
                state_r <= S_ADDR;
                byteIdx_r <= 3'h0;
                repCnt_r <= 5'h00;
              end
              syncCnt_r <= (syncCnt_r == `SYNC_LEN) ? syncCnt_r : syncCnt_r + 4'h1;
            end
            else
              syncCnt_r <= 4'h0;
          end
          S_ADDR:
          begin
            if (b == expByte) // [RULE_04]
            begin
              if (byteIdx_r == `ADDR_BYTES - 3'h1)
              begin
                byteIdx_r <= 3'h0;
                if (repCnt_r == `ADDR_REPS - 5'h01)
                begin
                  found_r <= 1'b1;
                  state_r <= S_SYNC;
                  syncCnt_r <= 4'h0;
                end
                repCnt_r <= repCnt_r + 5'h01;
              end
              else
                byteIdx_r <= byteIdx_r + 3'h1;
            end
            else if (b == `SYNC_BYTE && byteIdx_r == 3'h0 && repCnt_r == 5'h00)
            begin
              // Extra FF in a longer sync run keeps waiting for the address
              state_r <= S_ADDR;
            end
            else
            begin
              // Mismatch byte may itself begin a new sync run [RULE_15]
              state_r <= S_SYNC;
              byteIdx_r <= 3'h0;
              repCnt_r <= 5'h00;
              syncCnt_r <= (b == `SYNC_BYTE) ? 4'h1 : 4'h0;
            end
          end
          default:
            state_r <= S_SYNC;
        endcase
      end
    end
  end
  // ==========================================
  // Frame end decisions
  wire frameOk = crcGood && !overrun_r && (daOwn_r || daMcast_r || daBcast_r); // [RULE_08] [RULE_07]
  wire patHit = eof && inFrame_r && patternEnable && frameOk && found_r; // [RULE_03]
  reg frmHit;
  integer k;
  always @*
  begin
    frmHit = 1'b0;
    for (k = 0; k < NFRM; k = k + 1)
      if (wakeFrameEn[k] && crc == wakeFrameCrc[k*32 +: 32])
        frmHit = 1'b1; // [RULE_02]
  end
  // Programmed frames compare the residue after the FCS has been taken in
  wire userHit = eof && inFrame_r && wakeFrameMode && !overrun_r && frmHit;
  always @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      wakeStatus_r <= 3'h0;
      wakeRequest_r <= 1'b0;
      wake_pattern_frame_r <= 1'b0;
      frameDrop_r <= 1'b0;
    end
    else
    begin
      // Set beats clear on the same cycle [RULE_16] [RULE_17]
      wakeStatus_r[`STAT_LINK] <= linkChange | (wakeStatus_r[`STAT_LINK] & ~wakeStatusClr[0]);
      wakeStatus_r[`STAT_FRAME] <= userHit | (wakeStatus_r[`STAT_FRAME] & ~wakeStatusClr[1]);
      wakeStatus_r[`STAT_PATTERN] <= patHit | (wakeStatus_r[`STAT_PATTERN] & ~wakeStatusClr[2]);
      wakeRequest_r <= linkChange | userHit | patHit; // [RULE_11] [RULE_01]
      wake_pattern_frame_r <= patHit;
      frameDrop_r <= eof && inFrame_r && patternEnable && !patHit; // [RULE_10]
    end
  end
  // ==========================================
  // IPv6 offload controls
  assign txCsumInsert = txCsumStatic | tx_descriptor_word_one[0]; // [RULE_12]
  assign rxIpv6Drop = rxCsumFilterEn && rxIpv6 && rxL4CsumErr; // [RULE_13]
  reg aclAny;
  integer j;
  always @*
  begin
    aclAny = 1'b0;
    for (j = 0; j < NACL; j = j + 1)
      if (aclValid[j] &&
          aclAddr[j*128 +: 128] == (aclUseDest[j] ? rxDstIp : rxSrcIp))
        aclAny = 1'b1; // [RULE_14]
  end
  assign aclHit = aclAny;
endmodule // ethernet_wake_detect

// ==== dv/phy_model.sv ====
// Behavioural receive-side link partner driving framed bytes
`timescale 1ns/1ps
module phy_model (
  // Link outputs
  output logic rxClk,
  output logic rxDv,
  output logic [7:0] rxData
);
  initial
  begin
    rxClk = 1'b0;
    rxDv = 1'b0;
    rxData = 8'h00;
  end
  // ==========
  // Frame send
  // Odd start offset keeps the link clock unrelated to the system clock
  task automatic send(input logic [7:0] q[$]);
    #37;
    foreach (q[i])
    begin
      rxDv = 1'b1;
      rxData = q[i];
      #400 rxClk = 1'b1;
      #400 rxClk = 1'b0;
    end
    // Idle gap: released data must not look like the last byte
    rxDv = 1'b0;
    rxData = ~rxData;
    #400 rxClk = 1'b1;
    #400 rxClk = 1'b0;
  endtask
endmodule // phy_model

// ==== dv/ethernet_wake_detect_properties.sv ====
// Port-level assertion checker for the wake detection block
`timescale 1ns/1ps
module ethernet_wake_detect_properties (
  // Clock and reset
  input wire mclk,
  input wire reset_n,
  // Watched inputs
  input wire linkUp,
  input wire patternEnable,
  input wire txCsumStatic,
  input wire [31:0] tx_descriptor_word_one,
  input wire rxCsumFilterEn,
  input wire rxIpv6,
  input wire rxL4CsumErr,
  // Watched outputs
  input wire [2:0] wakeStatus_r,
  input wire wakeRequest_r,
  input wire wake_pattern_frame_r,
  input wire frameDrop_r,
  input wire txCsumInsert,
  input wire rxIpv6Drop
);
  // ==========
  // Properties
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);
  property p_csum; txCsumInsert == (txCsumStatic | tx_descriptor_word_one[0]); endproperty
  a_csum: assert property (p_csum) else $error("checksum insert mismatch");
  property p_v6drop; rxIpv6Drop == (rxCsumFilterEn & rxIpv6 & rxL4CsumErr); endproperty
  a_v6drop: assert property (p_v6drop) else $error("ipv6 drop mismatch");
  property p_req; wake_pattern_frame_r |-> wakeRequest_r; endproperty
  a_req: assert property (p_req) else $error("pattern without wake request");
  property p_stat; wake_pattern_frame_r |-> ##[0:1] wakeStatus_r[2]; endproperty
  a_stat: assert property (p_stat) else $error("pattern status not set");
  property p_pulse; wake_pattern_frame_r |=> !wake_pattern_frame_r; endproperty
  a_pulse: assert property (p_pulse) else $error("pattern pulse too long");
  property p_excl; !(frameDrop_r && wake_pattern_frame_r); endproperty
  a_excl: assert property (p_excl) else $error("drop and wake together");
  property p_en; (wake_pattern_frame_r || frameDrop_r) |-> patternEnable; endproperty
  a_en: assert property (p_en) else $error("scan result while disabled");
  property p_link; $changed(linkUp) |-> ##[1:8] wakeStatus_r[0]; endproperty
  a_link: assert property (p_link) else $error("link change not recorded");
  property p_cause;
    $rose(wakeStatus_r[2]) |-> wake_pattern_frame_r || $past(wake_pattern_frame_r);
  endproperty
  a_cause: assert property (p_cause) else $error("pattern status without cause");
  c_wake: cover property (wake_pattern_frame_r);
  c_drop: cover property (frameDrop_r);
  c_link: cover property ($rose(wakeStatus_r[0]));
endmodule // ethernet_wake_detect_properties
bind ethernet_wake_detect ethernet_wake_detect_properties chk_u (.mclk(mclk), .reset_n(reset_n),
  .linkUp(linkUp), .patternEnable(patternEnable), .txCsumStatic(txCsumStatic),
  .tx_descriptor_word_one(tx_descriptor_word_one), .rxCsumFilterEn(rxCsumFilterEn),
  .rxIpv6(rxIpv6), .rxL4CsumErr(rxL4CsumErr), .wakeStatus_r(wakeStatus_r),
  .wakeRequest_r(wakeRequest_r), .wake_pattern_frame_r(wake_pattern_frame_r),
  .frameDrop_r(frameDrop_r), .txCsumInsert(txCsumInsert), .rxIpv6Drop(rxIpv6Drop));

// ==== dv/tb.sv ====
// Self-checking testbench for the wake detection block
`timescale 1ns/1ps
module tb;
  logic mclk = 1'b0, reset_n = 1'b0, linkUp = 1'b0, patternEnable = 1'b0, wakeFrameMode = 1'b0;
  logic txCsumStatic = 1'b0, rxCsumFilterEn = 1'b0, rxIpv6 = 1'b0, rxL4CsumErr = 1'b0;
  logic [47:0] sta = 48'h0A1B2C3D4E5F;
  logic [127:0] wakeFrameCrc = {4{32'hDEBB20E3}}, rxSrcIp = 128'h0, rxDstIp = 128'h0;
  logic [3:0] wakeFrameEn = 4'h8;
  logic [31:0] tx_descriptor_word_one = 32'h0;
  logic [1023:0] aclAddr = 1024'h0;
  logic [7:0] aclUseDest = 8'h00, aclValid = 8'h00;
  logic [2:0] wakeStatusClr = 3'h0;
  wire rxClk, rxDv, wakeRequest_r, wake_pattern_frame_r, frameDrop_r;
  wire txCsumInsert, rxIpv6Drop, aclHit;
  wire [7:0] rxData;
  wire [2:0] wakeStatus_r;
  logic [7:0] fr[$];
  int fails = 0, total_checks = 0, nWake = 0, nDrop = 0, nReq = 0;
  always #50 mclk = ~mclk;
  phy_model phy_u (.rxClk(rxClk), .rxDv(rxDv), .rxData(rxData));
  ethernet_wake_detect dut_u (.mclk(mclk), .reset_n(reset_n), .rxClk(rxClk), .rxDv(rxDv),
    .rxData(rxData), .linkUp(linkUp), .patternEnable(patternEnable), .stationAddr(sta),
    .wakeFrameCrc(wakeFrameCrc), .wakeFrameEn(wakeFrameEn), .wakeFrameMode(wakeFrameMode),
    .txCsumStatic(txCsumStatic), .tx_descriptor_word_one(tx_descriptor_word_one),
    .rxCsumFilterEn(rxCsumFilterEn), .rxIpv6(rxIpv6), .rxL4CsumErr(rxL4CsumErr),
    .aclAddr(aclAddr), .aclUseDest(aclUseDest), .aclValid(aclValid), .rxSrcIp(rxSrcIp),
    .rxDstIp(rxDstIp), .wakeStatusClr(wakeStatusClr), .wakeStatus_r(wakeStatus_r),
    .wakeRequest_r(wakeRequest_r), .wake_pattern_frame_r(wake_pattern_frame_r),
    .frameDrop_r(frameDrop_r), .txCsumInsert(txCsumInsert), .rxIpv6Drop(rxIpv6Drop),
    .aclHit(aclHit));
  // Pulses are counted mid-cycle, away from the edge that launches them
  always @(negedge mclk)
  begin
    if (wake_pattern_frame_r === 1'b1) nWake++;
    if (frameDrop_r === 1'b1) nDrop++;
    if (wakeRequest_r === 1'b1) nReq++;
  end
  // ==========
  // Helpers
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      fails++;
      $display("ERROR %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic clr;
    @(negedge mclk);
    wakeStatusClr = 3'h7;
    @(negedge mclk);
    wakeStatusClr = 3'h0;
  endtask
  // Five FF then a stray byte forces a sync restart before the real run
  task automatic build(input logic [47:0] da, input int ff, input int reps, input bit bad);
    logic [31:0] c;
    fr = {};
    for (int i = 0; i < 6; i++) fr.push_back(da[47-8*i -: 8]);
    fr = {fr, 8'h02, 8'h11, 8'h22, 8'h33, 8'h44, 8'h55, 8'h86, 8'hDD};
    fr = {fr, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h5A};
    repeat (ff) fr.push_back(8'hFF);
    repeat (reps) for (int j = 0; j < 6; j++) fr.push_back(sta[47-8*j -: 8]);
    fr.push_back(8'h3C);
    c = 32'hFFFFFFFF;
    foreach (fr[k])
      for (int b = 0; b < 8; b++)
        c = (c >> 1) ^ ((c[0] ^ fr[k][b]) ? 32'hEDB88320 : 32'h0);
    c = ~c;
    if (bad) c[0] = ~c[0];
    for (int i = 0; i < 4; i++) fr.push_back(c[8*i +: 8]);
  endtask
  // A negative drop expectation leaves the drop pulse unchecked
  task automatic frame(input int w, input int d, input int u);
    nWake = 0;
    nDrop = 0;
    nReq = 0;
    phy_u.send(fr);
    repeat (20) @(negedge mclk);
    chk("patternPulses", nWake, w);
    if (d >= 0) chk("dropPulses", nDrop, d);
    chk("wakeRequests", nReq, w | u);
    chk("statusBits", wakeStatus_r, {29'h0, w[0], u[0], 1'b0});
    clr();
  endtask
  // ==========
  // Main sequence
  initial
  begin
    repeat (2) @(negedge mclk);
    reset_n = 1'b1;
    repeat (4) @(negedge mclk);
    chk("statusReset", wakeStatus_r, 3'h0);
    linkUp = 1'b1;
    repeat (10) @(negedge mclk);
    chk("linkUpStatus", wakeStatus_r, 3'h1);
    clr();
    linkUp = 1'b0;
    repeat (10) @(negedge mclk);
    chk("linkDownStatus", wakeStatus_r, 3'h1);
    clr();
    chk("statusCleared", wakeStatus_r, 3'h0);
    patternEnable = 1'b1;
    build(sta, 6, 16, 0);
    frame(1, 0, 0);
    build(sta, 6, 15, 0);
    frame(0, 1, 0);
    build(sta, 5, 16, 0);
    frame(0, 1, 0);
    build(sta, 8, 16, 0);
    frame(1, 0, 0);
    build(48'hFFFFFFFFFFFF, 6, 16, 0);
    frame(1, 0, 0);
    build(48'h010203040506, 6, 16, 0);
    frame(1, 0, 0);
    build(sta, 6, 16, 1);
    frame(0, 1, 0);
    build(48'h0A1B2C3D4E60, 6, 16, 0);
    frame(0, 1, 0);
    patternEnable = 1'b0;
    build(sta, 6, 16, 0);
    frame(0, 0, 0);
    wakeFrameMode = 1'b1;
    frame(0, 0, 1);
    wakeFrameEn = 4'h0;
    frame(0, 0, 0);
    for (int i = 0; i < 4; i++)
    begin
      @(negedge mclk);
      txCsumStatic = i[0];
      tx_descriptor_word_one = {31'h0, i[1]};
      #1 chk("csumInsert", txCsumInsert, i[0] | i[1]);
    end
    for (int i = 0; i < 8; i++)
    begin
      @(negedge mclk);
      {rxCsumFilterEn, rxIpv6, rxL4CsumErr} = i[2:0];
      #1 chk("ipv6Drop", rxIpv6Drop, &i[2:0]);
    end
    @(negedge mclk);
    aclAddr[1023 -: 128] = {8{16'hFE81}};
    {aclValid, aclUseDest} = 16'h8080;
    rxDstIp = {8{16'hFE81}};
    #1 chk("aclDest", aclHit, 1'b1);
    @(negedge mclk);
    {rxDstIp, rxSrcIp} = {128'h0, {8{16'hFE81}}};
    #1 chk("aclDestMiss", aclHit, 1'b0);
    @(negedge mclk);
    aclUseDest = 8'h00;
    #1 chk("aclSrc", aclHit, 1'b1);
    @(negedge mclk);
    aclValid = 8'h00;
    #1 chk("aclInvalid", aclHit, 1'b0);
    summarize();
  end
  initial
  begin
    #4000000;
    fails++;
    summarize();
  end
endmodule // tb
